// file: hdl/bsp_serial_port.v
// Purpose: serial command and data port of a bridge adc, device side
// Assumes: sys_clk 250 MHz; shift clock, chip select, serial in, master
//          clock and wiring-mode pin are asynchronous and are synchronised here; polarity select is not
// Notes:   bits are taken on the rising shift clock edge and launched on
//          the falling edge; msb first; 24-bit words after an 8-bit command
`timescale 1ns/1ps
`include "bsp_regs.vh"
module bsp_serial_port
(
  input  wire                  sys_clk,
  input  wire                  rst_n,
  input  wire                  shift_clk,
  input  wire                  chip_select_n,
  input  wire                  serial_in_line,
  input  wire                  wiring_mode_select,
  input  wire                  master_clock_in,
  input  wire                  polarity_select,
  input  wire                  adc_valid,
  output wire                  adc_ready,
  input  wire [`BSP_RES_W-1:0] adc_data,
  output reg                   serial_out_line,
  output wire                  serial_out_oe,
  output reg                   conversion_ready_n,
  output reg                   sleep_active,
  output reg                   calibrating,
  output reg                   filter_restart,
  output reg  [`BSP_WORD_W-1:0] cfg_word,
  output reg  [`BSP_WORD_W-1:0] gain_word,
  output reg  [`BSP_WORD_W-1:0] dac_word,
  output reg  [`BSP_WORD_W-1:0] ofs_a_word,
  output reg  [`BSP_WORD_W-1:0] ofs_b_word,
  output reg  [`BSP_WORD_W-1:0] ofs_c_word
);
  // port states, one-hot
  localparam ST_CMD  = 4'b0001;
  localparam ST_WIN  = 4'b0010;
  localparam ST_WOUT = 4'b0100;
  localparam ST_CAL  = 4'b1000;

  wire                   sclk_s;
  wire                   csn_s;
  wire                   sin_s;
  wire                   mode3_s;
  wire                   mclk_s;
  reg                    sclk_d;
  reg                    mclk_d;
  reg  [3:0]             state;
  reg  [`BSP_BIT_CNT_W-1:0] bit_cnt;
  reg  [`BSP_WORD_W-1:0] shreg;
  reg  [`BSP_CMD_W-1:0]  cmd;
  reg  [`BSP_CONV_CNT_W-1:0] conv_cnt;
  reg  [2:0]             load_cnt;
  reg  [7:0]             cal_cnt;
  reg  [`BSP_RES_W-1:0]  result;
  reg                    result_pend;
  reg                    restart_pend;
  reg                    transmitting;
  wire                   sclk_rise;
  wire                   sclk_fall;
  wire                   mclk_rise;
  wire                   selected;
  wire                   conv_tick;
  wire                   fifo_valid;
  wire [`BSP_RES_W-1:0]  fifo_data;
  wire                   fifo_take;
  wire [2:0]             cmd_sel;

  // signed to offset binary coding for bipolar results
  function [`BSP_RES_W-1:0] code_word;
    input [`BSP_RES_W-1:0] raw;
    input                  bipolar;
    begin
      code_word = bipolar ? (raw ^ `BSP_MID_SCALE) : raw;
    end
  endfunction

  // ------------------------------------------------------------
  // pin synchronisers
  // ------------------------------------------------------------
  bsp_sync u_sync_sclk (.sys_clk(sys_clk), .rst_n(rst_n), .async_in(shift_clk),          .sync_out(sclk_s));
  bsp_sync u_sync_csn  (.sys_clk(sys_clk), .rst_n(rst_n), .async_in(chip_select_n),      .sync_out(csn_s));
  bsp_sync u_sync_sin  (.sys_clk(sys_clk), .rst_n(rst_n), .async_in(serial_in_line),     .sync_out(sin_s));
  bsp_sync u_sync_mode (.sys_clk(sys_clk), .rst_n(rst_n), .async_in(wiring_mode_select), .sync_out(mode3_s));
  bsp_sync u_sync_mclk (.sys_clk(sys_clk), .rst_n(rst_n), .async_in(master_clock_in),    .sync_out(mclk_s));

  // ------------------------------------------------------------
  // result buffer between converter core and output port
  // ------------------------------------------------------------
  bsp_fifo #(.WIDTH(`BSP_RES_W), .DEPTH(4), .AW(2)) u_fifo
  (
    .sys_clk   (sys_clk),
    .rst_n     (rst_n),
    .in_valid  (adc_valid && !sleep_active),
    .in_ready  (adc_ready),
    .in_data   (adc_data),
    .out_valid (fifo_valid),
    .out_ready (fifo_take),
    .out_data  (fifo_data),
    .flush     (filter_restart)
  );

  // ------------------------------------------------------------
  // edge detection on synchronised pins
  // ------------------------------------------------------------
  always @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      sclk_d <= 1'b0;
      mclk_d <= 1'b0;
    end
    else
    begin
      sclk_d <= sclk_s;
      mclk_d <= mclk_s;
    end
  end

  // 3-wire mode ignores chip select, 4/5-wire needs it low
  assign selected  = mode3_s || !csn_s;
  assign sclk_rise = selected && sclk_s && !sclk_d;
  assign sclk_fall = selected && !sclk_s && sclk_d;
  assign mclk_rise = mclk_s && !mclk_d;
  assign conv_tick = mclk_rise && (conv_cnt == `BSP_CONV_PERIOD - 17'd1);
  assign cmd_sel   = cmd[`BSP_SEL_HI:`BSP_SEL_LO];
  // next result is pulled at a conversion tick once the previous one is gone and no load runs
  assign fifo_take = conv_tick && !result_pend && (load_cnt == 3'd0)
                     && !calibrating && !sleep_active;

  // pin is driven always in 3-wire mode, else only while sending
  assign serial_out_oe = mode3_s || (!csn_s && transmitting);

  // ------------------------------------------------------------
  // master clock divider paces output word updates
  // ------------------------------------------------------------
  always @(posedge sys_clk)
  begin
    if (!rst_n || filter_restart)
      conv_cnt <= {`BSP_CONV_CNT_W{1'b0}};
    else if (sleep_active)
      conv_cnt <= conv_cnt;
    else if (conv_tick)
      conv_cnt <= {`BSP_CONV_CNT_W{1'b0}};
    else if (mclk_rise)
      conv_cnt <= conv_cnt + 17'd1;
  end

  // ------------------------------------------------------------
  // output port load and ready flag
  // ------------------------------------------------------------
  always @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      result             <= `BSP_RES_ZERO;
      result_pend        <= 1'b0;
      load_cnt           <= 3'd0;
      conversion_ready_n <= 1'b1;
    end
    else
    begin
      if (fifo_take && fifo_valid)
      begin
        result   <= code_word(fifo_data, polarity_select);
        load_cnt <= `BSP_LOAD_CYCLES;
      end
      else if (load_cnt != 3'd0)
        load_cnt <= load_cnt - 3'd1;
      // high during load, calibration and sleep
      if (load_cnt != 3'd0 || calibrating || sleep_active)
      begin
        conversion_ready_n <= 1'b1;
        if (load_cnt == 3'd1)
          result_pend <= 1'b1;
      end
      else if (state == ST_WOUT && cmd_sel == `BSP_SEL_CONV && bit_cnt == `BSP_WORD_BITS)
      begin
        conversion_ready_n <= 1'b1;
        result_pend        <= 1'b0;
      end
      else if (result_pend && cmd_sel == `BSP_SEL_CONV)
        conversion_ready_n <= 1'b0;
    end
  end

  // ------------------------------------------------------------
  // serial port state machine
  // ------------------------------------------------------------
  always @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      state           <= ST_CMD;
      bit_cnt         <= {`BSP_BIT_CNT_W{1'b0}};
      shreg           <= {`BSP_WORD_W{1'b0}};
      cmd             <= {`BSP_CMD_W{1'b0}};
      transmitting    <= 1'b0;
      serial_out_line <= 1'b0;
      cal_cnt         <= 8'd0;
      calibrating     <= 1'b0;
      restart_pend    <= 1'b0;
      filter_restart  <= 1'b0;
      cfg_word        <= `BSP_CFG_RST;
      gain_word       <= `BSP_GAIN_RST;
      dac_word        <= `BSP_DAC_RST;
      ofs_a_word      <= `BSP_OFS_RST;
      ofs_b_word      <= `BSP_OFS_RST;
      ofs_c_word      <= `BSP_OFS_RST;
      sleep_active    <= 1'b0;
    end
    else
    begin
      filter_restart <= 1'b0;
      // restart waits for the next master clock rise
      if (restart_pend && mclk_rise)
      begin
        filter_restart <= 1'b1;
        restart_pend   <= 1'b0;
      end
      // a dropped select aborts a half-shifted word
      if (!selected && state != ST_CAL)
      begin
        state        <= ST_CMD;
        bit_cnt      <= {`BSP_BIT_CNT_W{1'b0}};
        transmitting <= 1'b0;
      end
      else
      begin
        case (state)
          ST_CMD:
          begin
            if (sclk_rise)
            begin
              shreg   <= {shreg[`BSP_WORD_W-2:0], sin_s};
              bit_cnt <= bit_cnt + 5'd1;
            end
            else if (bit_cnt == `BSP_CMD_BITS)
            begin
              cmd     <= shreg[`BSP_CMD_W-1:0];
              bit_cnt <= {`BSP_BIT_CNT_W{1'b0}};
              if (shreg[`BSP_CMD_WR_BIT])
                state <= ST_WIN;
              else if (shreg[`BSP_SEL_HI:`BSP_SEL_LO] == `BSP_SEL_CAL)
              begin
                state       <= ST_CAL;
                calibrating <= 1'b1;
                cal_cnt     <= `BSP_CAL_CYCLES;
              end
              else
              begin
                state <= ST_WOUT;
                case (shreg[`BSP_SEL_HI:`BSP_SEL_LO])
                  `BSP_SEL_CONV:  shreg <= {result, 4'h0};
                  `BSP_SEL_CFG:   shreg <= cfg_word;
                  `BSP_SEL_GAIN:  shreg <= gain_word;
                  `BSP_SEL_DAC:   shreg <= dac_word;
                  `BSP_SEL_OFS_A: shreg <= ofs_a_word;
                  `BSP_SEL_OFS_B: shreg <= ofs_b_word;
                  `BSP_SEL_OFS_C: shreg <= ofs_c_word;
                  default:        shreg <= {`BSP_WORD_W{1'b0}};
                endcase
              end
            end
          end
          ST_WIN:
          begin
            if (sclk_rise)
            begin
              shreg   <= {shreg[`BSP_WORD_W-2:0], sin_s};
              bit_cnt <= bit_cnt + 5'd1;
            end
            else if (sclk_fall && bit_cnt == `BSP_WORD_BITS)
            begin
              state   <= ST_CMD;
              bit_cnt <= {`BSP_BIT_CNT_W{1'b0}};
              case (cmd[`BSP_SEL_HI:`BSP_SEL_LO])
                `BSP_SEL_CFG:
                begin
                  cfg_word     <= shreg;
                  sleep_active <= shreg[`BSP_CFG_SLEEP];
                  restart_pend <= shreg[`BSP_CFG_RESTART];
                end
                `BSP_SEL_GAIN:  gain_word  <= shreg;
                `BSP_SEL_DAC:   dac_word   <= shreg;
                `BSP_SEL_OFS_A: ofs_a_word <= shreg;
                `BSP_SEL_OFS_B: ofs_b_word <= shreg;
                `BSP_SEL_OFS_C: ofs_c_word <= shreg;
                default:        cfg_word   <= cfg_word;
              endcase
            end
          end
          ST_WOUT:
          begin
            if (sclk_fall && bit_cnt != `BSP_WORD_BITS)
            begin
              transmitting    <= 1'b1;
              serial_out_line <= shreg[`BSP_WORD_W-1];
              shreg           <= {shreg[`BSP_WORD_W-2:0], 1'b0};
              bit_cnt         <= bit_cnt + 5'd1;
            end
            else if (sclk_fall)
            begin
              transmitting <= 1'b0;
              state        <= ST_CMD;
              bit_cnt      <= {`BSP_BIT_CNT_W{1'b0}};
            end
          end
          ST_CAL:
          begin
            if (cal_cnt == 8'd0)
            begin
              calibrating <= 1'b0;
              state       <= ST_CMD;
            end
            else
              cal_cnt <= cal_cnt - 8'd1;
          end
          default:
            state <= ST_CMD;
        endcase
      end
    end
  end
endmodule

// file: common/bsp_regs.vh
// Purpose: constants for the bridge adc serial port block
// Assumes: sys_clk at 250 MHz, 24-bit serial words, 8-bit command byte
// Notes:   timing counts are given directly as cycle numbers, not derived from named times
//
// Summary of operation
// - reset clears every calibration register to its default and puts the port back into waiting for a command.
// - with the wiring-mode select low and chip select high the serial output is not driven.
// - the host shift clock alone paces the bits shifted out and the bits sampled in.
// - the serial input level is ignored whenever no bits are being shifted in.
// - wiring-mode select low gives 4/5-wire mode and high gives 3-wire mode.
// - in read-conversion-data state the ready output goes low once every 81,920 master clock cycles.
// - the ready output returns high once the host has shifted out every bit of pending data.
// - the ready output stays high while the output port loads, while calibrating and while asleep.
// - the word shifted out is a conversion result or a calibration value, chosen by the last command.
// - with wiring-mode select low the serial output is not driven while no bits are being sent.
// - polarity select low means unipolar and high means bipolar, with mid-scale between 7FFFF and 80000.
// - after the 24th shift clock edge falls a new filter convolution starts on the next master clock rise.
// - writing the sleep bit to one shuts the core down, and reset clears it to awake.
`ifndef BSP_REGS_VH
`define BSP_REGS_VH

`define BSP_WORD_W        24
`define BSP_CMD_W         8
`define BSP_RES_W         20
`define BSP_BIT_CNT_W     5
`define BSP_WORD_BITS     5'd24
`define BSP_CMD_BITS      5'd8
`define BSP_CONV_PERIOD   17'd81920
`define BSP_CONV_CNT_W    17
`define BSP_LOAD_CYCLES   3'd4
`define BSP_CAL_CYCLES    8'd200

// command byte layout: bit 7 write, bits 2:0 register select
`define BSP_CMD_WR_BIT    7
`define BSP_SEL_HI        2
`define BSP_SEL_LO        0
`define BSP_SEL_CONV      3'h0
`define BSP_SEL_CFG       3'h1
`define BSP_SEL_GAIN      3'h2
`define BSP_SEL_DAC       3'h3
`define BSP_SEL_OFS_A     3'h4
`define BSP_SEL_OFS_B     3'h5
`define BSP_SEL_OFS_C     3'h6
`define BSP_SEL_CAL       3'h7

// configuration word fields
`define BSP_CFG_SLEEP     0
`define BSP_CFG_RESTART   1

`define BSP_CFG_RST       24'h000000
`define BSP_GAIN_RST      24'h400000
`define BSP_DAC_RST       24'h000000
`define BSP_OFS_RST       24'h000000
`define BSP_MID_SCALE     20'h80000
`define BSP_RES_ZERO      20'h00000

`endif

// file: hdl/bsp_sync.v
// Purpose: two-flop synchroniser for one level
// Assumes: input asynchronous to sys_clk
// Notes:   first stage is read by the second stage only
`timescale 1ns/1ps
module bsp_sync
(
  input  wire sys_clk,
  input  wire rst_n,
  input  wire async_in,
  output reg  sync_out
);
  reg meta;

  // ------------------------------------------------------------
  // two stages
  // ------------------------------------------------------------
  always @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      meta     <= 1'b0;
      sync_out <= 1'b0;
    end
    else
    begin
      meta     <= async_in;
      sync_out <= meta;
    end
  end
endmodule

// file: hdl/bsp_fifo.v
// Purpose: small flip-flop fifo for result words
// Assumes: one clock, synchronous active-low reset
// Notes:   width and depth are parameters; depth a power of two
`timescale 1ns/1ps
module bsp_fifo
#(
  parameter WIDTH = 20,
  parameter DEPTH = 4,
  parameter AW    = 2
)
(
  input  wire             sys_clk,
  input  wire             rst_n,
  input  wire             in_valid,
  output wire             in_ready,
  input  wire [WIDTH-1:0] in_data,
  output wire             out_valid,
  input  wire             out_ready,
  output wire [WIDTH-1:0] out_data,
  input  wire             flush
);
  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW-1:0]    wr_ptr;
  reg [AW-1:0]    rd_ptr;
  reg [AW:0]      count;
  wire            do_wr;
  wire            do_rd;

  // ------------------------------------------------------------
  // flags and handshake
  // ------------------------------------------------------------
  assign in_ready  = (count != DEPTH[AW:0]);
  assign out_valid = (count != {(AW+1){1'b0}});
  assign out_data  = mem[rd_ptr];
  assign do_wr     = in_valid && in_ready;
  assign do_rd     = out_valid && out_ready;

  // ------------------------------------------------------------
  // storage and pointers
  // ------------------------------------------------------------
  always @(posedge sys_clk)
  begin
    if (!rst_n || flush)
    begin
      wr_ptr <= {AW{1'b0}};
      rd_ptr <= {AW{1'b0}};
      count  <= {(AW+1){1'b0}};
    end
    else
    begin
      if (do_wr)
      begin
        mem[wr_ptr] <= in_data;
        wr_ptr      <= wr_ptr + 1'b1;
      end
      if (do_rd)
        rd_ptr <= rd_ptr + 1'b1;
      if (do_wr && !do_rd)
        count <= count + 1'b1;
      else if (do_rd && !do_wr)
        count <= count - 1'b1;
    end
  end
endmodule

// file: verif/bsp_port_properties.sv
// Purpose: concurrent checks on the serial port pins and status flags
// Assumes: pins pass two synchronising flops and an edge register
// Notes:   windows leave room for that synchroniser delay
`timescale 1ns/1ps
module bsp_port_checker
(
  input wire logic        sys_clk,
  input wire logic        rst_n,
  input wire logic        shift_clk,
  input wire logic        chip_select_n,
  input wire logic        wiring_mode_select,
  input wire logic        serial_out_line,
  input wire logic        serial_out_oe,
  input wire logic        conversion_ready_n,
  input wire logic        sleep_active,
  input wire logic        calibrating,
  input wire logic        filter_restart,
  input wire logic [23:0] gain_word
);
  // ------------------------------------------
  // pin and status properties
  // ------------------------------------------
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  // reset is the cause here, so it must not disable the check
  a_reset_defaults: assert property (disable iff (1'b0) !rst_n |=> gain_word == 24'h400000 && !sleep_active)
    else $error("reset left a word or flag off its default");
  a_ready_reset_high: assert property (disable iff (1'b0) !rst_n |=> conversion_ready_n)
    else $error("ready not high after reset");
  a_oe_three_wire: assert property (wiring_mode_select [*5] |-> serial_out_oe)
    else $error("output not driven in three wire mode");
  a_oe_cs_high: assert property ((!wiring_mode_select && chip_select_n) [*5] |-> !serial_out_oe)
    else $error("output driven while deselected");
  a_ready_sleep_hold: assert property (sleep_active && $past(sleep_active, 2) |-> conversion_ready_n)
    else $error("ready low while asleep");
  a_ready_cal_hold: assert property (calibrating && $past(calibrating, 2) |-> conversion_ready_n)
    else $error("ready low while calibrating");
  a_cal_span: assert property ($rose(calibrating) |-> ##[190:210] $fell(calibrating))
    else $error("calibration length off");
  a_ready_fall_cause: assert property ($fell(conversion_ready_n) |-> !sleep_active && !calibrating)
    else $error("ready fell while busy");
  a_restart_pulse: assert property (filter_restart |=> !filter_restart)
    else $error("restart pulse longer than one cycle");
  // launch only follows a falling shift clock, so the pin is low then
  a_out_on_fall: assert property ($changed(serial_out_line) && !wiring_mode_select |-> !shift_clk)
    else $error("output bit changed while shift clock high");
endmodule
bind bsp_serial_port bsp_port_checker chk_u (.sys_clk(sys_clk), .rst_n(rst_n), .shift_clk(shift_clk),
  .chip_select_n(chip_select_n), .wiring_mode_select(wiring_mode_select), .serial_out_line(serial_out_line),
  .serial_out_oe(serial_out_oe), .conversion_ready_n(conversion_ready_n), .sleep_active(sleep_active),
  .calibrating(calibrating), .filter_restart(filter_restart), .gain_word(gain_word));

// file: verif/bsp_host_model.sv
// Purpose: host side of the serial port, shift clock and chip select
// Assumes: shift clock idles low, 80 ns period, msb first
// Notes:   released data line shows the inverse of its last bit
`timescale 1ns/1ps
module bsp_host_model
(
  input wire logic sys_clk,
  input wire logic serial_out_line,
  input wire logic serial_out_oe,
  output logic     shift_clk,
  output logic     chip_select_n,
  output logic     serial_in_line
);
  // ------------------------------------------
  // transfer tasks
  // ------------------------------------------
  initial
  begin
    shift_clk = 1'b0;
    chip_select_n = 1'b1;
    serial_in_line = 1'b0;
  end
  // half a shift clock period is ten system cycles
  task half;
    repeat (10) @(negedge sys_clk);
  endtask
  // host clock alone paces both directions
  task xfer(input [7:0] cmd, input [23:0] wd, input integer nb, input use_cs, output [23:0] rd);
    integer i;
    reg [31:0] sh;
    begin
      sh = {cmd, wd};
      rd = 24'h0;
      chip_select_n = !use_cs;
      half;
      for (i = 31; i >= 32 - nb; i = i - 1)
      begin
        serial_in_line = sh[i];
        half;
        if (i < 24)
          rd[i] = serial_out_oe ? serial_out_line : ~serial_out_line;
        shift_clk = 1'b1;
        half;
        shift_clk = 1'b0;
      end
      half;
      serial_in_line = ~sh[32 - nb];
      chip_select_n = 1'b1;
      half;
    end
  endtask
  // stray edges with chip select high must be refused
  task stray(input integer n);
    repeat (n)
    begin
      serial_in_line = ~serial_in_line;
      half;
      shift_clk = ~shift_clk;
    end
    half;
    shift_clk = 1'b0;
  endtask
endmodule

// file: verif/bsp_serial_port_tb_top.sv
// Purpose: self-checking bench for the serial port block
// Assumes: inputs change at falling sys_clk, master clock at sys_clk/2
// Notes:   one full conversion period runs, so the run is long
`timescale 1ns/1ps
module bsp_serial_port_tb_top;
  reg         sys_clk, rst_n, wiring_mode_select, master_clock_in;
  reg         polarity_select, adc_valid, mclk_run, took, restart_seen;
  reg  [19:0] adc_data;
  reg  [23:0] rd, pat;
  wire        shift_clk, chip_select_n, serial_in_line, adc_ready, serial_out_line;
  wire        serial_out_oe, conversion_ready_n, sleep_active, calibrating, filter_restart;
  wire [23:0] cfg_word, gain_word, dac_word, ofs_a_word, ofs_b_word, ofs_c_word;
  integer     mismatches, checks_done, i, n;
  // ------------------------------------------
  // clock, instances and helpers
  // ------------------------------------------
  initial
  begin
    sys_clk = 1'b0;
    forever #2 sys_clk = ~sys_clk;
  end
  // toggles every cycle: fastest rate the synchroniser still resolves
  always @(negedge sys_clk)
    if (mclk_run)
      master_clock_in <= ~master_clock_in;
  always @(posedge sys_clk)
    if (filter_restart)
      restart_seen <= 1'b1;
  bsp_serial_port dut_u (.sys_clk(sys_clk), .rst_n(rst_n), .shift_clk(shift_clk), .chip_select_n(chip_select_n),
    .serial_in_line(serial_in_line), .wiring_mode_select(wiring_mode_select), .master_clock_in(master_clock_in),
    .polarity_select(polarity_select), .adc_valid(adc_valid), .adc_ready(adc_ready), .adc_data(adc_data),
    .serial_out_line(serial_out_line), .serial_out_oe(serial_out_oe), .conversion_ready_n(conversion_ready_n),
    .sleep_active(sleep_active), .calibrating(calibrating), .filter_restart(filter_restart), .cfg_word(cfg_word),
    .gain_word(gain_word), .dac_word(dac_word), .ofs_a_word(ofs_a_word), .ofs_b_word(ofs_b_word),
    .ofs_c_word(ofs_c_word));
  bsp_host_model host_u (.sys_clk(sys_clk), .serial_out_line(serial_out_line), .serial_out_oe(serial_out_oe),
    .shift_clk(shift_clk), .chip_select_n(chip_select_n), .serial_in_line(serial_in_line));
  task chk(input [23:0] seen, input [23:0] exp);
    begin
      checks_done = checks_done + 1;
      if (seen !== exp)
      begin
        mismatches = mismatches + 1;
        $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
      end
    end
  endtask
  function [23:0] word_of(input [2:0] s);
    case (s)
      3'h1: word_of = cfg_word;
      3'h2: word_of = gain_word;
      3'h3: word_of = dac_word;
      3'h4: word_of = ofs_a_word;
      3'h5: word_of = ofs_b_word;
      default: word_of = ofs_c_word;
    endcase
  endfunction
  task conclude;
    begin
      $display("checks %0d mismatches %0d", checks_done, mismatches);
      if (mismatches == 0 && checks_done > 0)
        $display("All tests passed");
      else
        $display("Some tests failed");
      $finish;
    end
  endtask
  // ------------------------------------------
  // test sequence
  // ------------------------------------------
  initial
  begin
    {rst_n, wiring_mode_select, master_clock_in, polarity_select, adc_valid, mclk_run, restart_seen} = 7'h0;
    adc_data = 20'h0;
    mismatches = 0;
    checks_done = 0;
    repeat (3) @(negedge sys_clk);
    rst_n = 1'b1;
    repeat (6) @(negedge sys_clk);
    chk(gain_word, 24'h400000);
    chk(cfg_word | dac_word | ofs_a_word | ofs_b_word | ofs_c_word, 24'h0);
    chk({sleep_active, conversion_ready_n, serial_out_oe}, 24'h2);
    $display("test reset done");
    // every writable select, written then read back
    for (i = 1; i <= 6; i = i + 1)
    begin
      pat = (i == 1) ? 24'h0 : {8'hC3, 5'h0, i[2:0], 8'h5A};
      host_u.xfer({5'h10, i[2:0]}, pat, 32, 1'b1, rd);
      chk(word_of(i[2:0]), pat);
      host_u.xfer({5'h00, i[2:0]}, ~pat, 32, 1'b1, rd);
      chk(rd, pat);
    end
    host_u.stray(40);
    chk(gain_word, 24'hC3025A);
    chk(serial_out_oe, 24'h0);
    $display("test registers done");
    wiring_mode_select = 1'b1;
    repeat (6) @(negedge sys_clk);
    chk(serial_out_oe, 24'h1);
    host_u.xfer(8'h83, 24'h00F00F, 32, 1'b0, rd);
    chk(dac_word, 24'h00F00F);
    wiring_mode_select = 1'b0;
    $display("test three wire done");
    host_u.xfer(8'h81, 24'h000001, 32, 1'b1, rd);
    chk({sleep_active, conversion_ready_n}, 24'h3);
    host_u.xfer(8'h81, 24'h000000, 32, 1'b1, rd);
    chk(sleep_active, 24'h0);
    host_u.xfer(8'h07, 24'h0, 8, 1'b1, rd);
    chk({calibrating, conversion_ready_n}, 24'h3);
    n = 0;
    while (calibrating && n < 400)
    begin
      @(negedge sys_clk);
      n = n + 1;
    end
    chk(calibrating, 24'h0);
    $display("test sleep and calibration done");
    mclk_run = 1'b1;
    host_u.xfer(8'h81, 24'h000002, 32, 1'b1, rd);
    repeat (20) @(negedge sys_clk);
    chk(restart_seen, 24'h1);
    host_u.xfer(8'h81, 24'h000000, 32, 1'b1, rd);
    // fill the result buffer until it refuses
    polarity_select = 1'b1;
    n = 0;
    repeat (6)
    begin
      adc_data = n[19:0];
      adc_valid = 1'b1;
      took = adc_ready;
      @(negedge sys_clk);
      n = n + took;
    end
    adc_valid = 1'b0;
    chk(n, 24'h4);
    chk(adc_ready, 24'h0);
    host_u.xfer(8'h00, 24'h0, 32, 1'b1, rd);
    n = 0;
    while (conversion_ready_n && n < 200000)
    begin
      @(negedge sys_clk);
      n = n + 1;
    end
    chk(conversion_ready_n, 24'h0);
    // one period is 81920 master rises at two system cycles each, less the time since restart
    chk(n > 160000 && n < 164000, 24'h1);
    chk(adc_ready, 24'h1);
    host_u.xfer(8'h00, 24'h0, 32, 1'b1, rd);
    chk(rd, {20'h80000, 4'h0});
    chk(conversion_ready_n, 24'h1);
    $display("test conversion done");
    conclude;
  end
  initial
  begin
    #2000000;
    mismatches = mismatches + 1;
    conclude;
  end
endmodule
